//--- logic/iwra_fifo.sv
// FIFO: flip-flop storage with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module iwra_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic  mclk_i,
  input  wire logic  rst_b_i,
  // Fill and drain sides
  iwra_fifo_if.sink  wr,
  iwra_fifo_if.src   rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr, rptr, next_wptr, next_rptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  // Handshakes; full and empty come straight from the count
  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rptr];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  // Pointer arithmetic
  always_comb
  begin
    next_wptr  = push ? ((wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1) : wptr;
    next_rptr  = pop  ? ((rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1) : rptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else
    begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end

  // Storage carries no reset
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wptr] <= wr.data;
  end
endmodule : iwra_fifo
`default_nettype wire

//--- logic/iwra_fifo_if.sv
// Interface: valid/ready byte stream between the target and its FIFO
`timescale 1ns/100ps
`default_nettype none
interface iwra_fifo_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : iwra_fifo_if
`default_nettype wire

//--- logic/iwra_pkg.sv
// Package: constants shared by the wiper register I2C target
package iwra_pkg;
  localparam logic [7:0] IWRA_OFS_POSITION   = 8'h00;
  localparam logic [7:0] IWRA_OFS_ACCESS_SEL = 8'h02;
  localparam logic [7:0] IWRA_SEL_WIPER      = 8'h80;
  localparam logic [7:0] IWRA_SEL_STORED     = 8'h00;
  // Device type codes; the regular one is arbitrary, the step code is fixed
  localparam logic [4:0] IWRA_TYPE_ACCESS    = 5'h0C;
  localparam logic [4:0] IWRA_TYPE_STEP      = 5'h0B;
  localparam logic [6:0] IWRA_POS_MIN        = 7'h00;
  localparam logic [6:0] IWRA_POS_MAX        = 7'h7F;
  localparam logic [6:0] IWRA_STORED_RESET   = 7'h40;
  localparam int         IWRA_CLK_MHZ        = 125;
  localparam int         IWRA_STORE_TIME_US  = 5000;
  localparam int         IWRA_STORE_CYCLES   = IWRA_STORE_TIME_US * IWRA_CLK_MHZ;
  localparam int         IWRA_FIFO_DEPTH     = 8;
  localparam int         IWRA_FIFO_WIDTH     = 8;
endpackage : iwra_pkg

//--- logic/iwra_target.sv
// I2C target that reads, writes and steps the wiper position registers
`timescale 1ns/100ps
`default_nettype none
module iwra_target
  import iwra_pkg::*;
#(
  parameter int STORE_CYCLES = iwra_pkg::IWRA_STORE_CYCLES
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // I2C pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Address select straps
  input  wire logic       addr_select_hi_i,
  input  wire logic       addr_select_lo_i,
  // Register state
  output logic [6:0]      wiper_position_o,
  output logic [6:0]      stored_position_o,
  output logic            store_busy_o
);
  import iwra_pkg::*;

  typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK, ST_STEP, ST_WAIT} iwra_state_t;

  // Two-flop synchronisers, then one more stage for edge detection
  logic [1:0] scl_sync, sda_sync;
  logic       scl_d, sda_d, a_hi_s, a_lo_s, a_hi_q, a_lo_q;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      a_hi_s   <= 1'b0;
      a_lo_s   <= 1'b0;
      a_hi_q   <= 1'b0;
      a_lo_q   <= 1'b0;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
      a_hi_s   <= addr_select_hi_i;
      a_lo_s   <= addr_select_lo_i;
      a_hi_q   <= a_hi_s;
      a_lo_q   <= a_lo_s;
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  assign scl      = scl_sync[1];
  assign sda      = sda_sync[1];
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign start_c  = scl && scl_d && sda_d && !sda;
  assign stop_c   = scl && scl_d && !sda_d && sda;

  // Saturating step, shared by both directions
  function automatic logic [6:0] step_pos(input logic [6:0] p, input logic up);
    if (up)
      return (p == IWRA_POS_MAX) ? p : p + 7'h01;
    else
      return (p == IWRA_POS_MIN) ? p : p - 7'h01;
  endfunction

  // Received bytes go through the FIFO to the register decoder
  iwra_fifo_if #(.WIDTH(IWRA_FIFO_WIDTH)) rx_if ();
  iwra_fifo_if #(.WIDTH(IWRA_FIFO_WIDTH)) dec_if ();
  iwra_fifo #(.WIDTH(IWRA_FIFO_WIDTH), .DEPTH(IWRA_FIFO_DEPTH)) u_fifo (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .wr      (rx_if.sink),
    .rd      (dec_if.src)
  );

  iwra_state_t state, next_state;
  logic [7:0]  shift, next_shift;
  logic [3:0]  bitn, next_bitn;
  logic [1:0]  byten, next_byten;
  logic        rw, next_rw, step_mode, next_step_mode;
  logic        sel_wiper, next_sel_wiper;
  logic [7:0]  offset, next_offset;
  logic [6:0]  wiper, next_wiper, stored, next_stored;
  logic [6:0]  pend, next_pend;
  logic        pend_v, next_pend_v;
  logic        so, next_so, soe, next_soe;
  logic [$clog2(STORE_CYCLES+1)-1:0] store_cnt, next_store_cnt;
  logic        init, next_init;
  logic        rx_valid, next_rx_valid;
  logic [7:0]  rx_data, next_rx_data;
  logic        addr_ok;
  logic        dec_first, next_dec_first;

  assign rx_if.valid  = rx_valid;
  assign rx_if.data   = rx_data;
  assign dec_if.ready = 1'b1;
  // First byte matches the access code or the step code plus the pins
  assign addr_ok = (shift[2:1] == {a_hi_q, a_lo_q}) &&
                   (shift[7:3] == IWRA_TYPE_ACCESS || shift[7:3] == IWRA_TYPE_STEP);

  // Next-state logic for the bus engine and registers
  always_comb
  begin
    next_state     = state;
    next_shift     = shift;
    next_bitn      = bitn;
    next_byten     = byten;
    next_rw        = rw;
    next_step_mode = step_mode;
    next_sel_wiper = sel_wiper;
    next_offset    = offset;
    next_wiper     = wiper;
    next_stored    = stored;
    next_pend      = pend;
    next_pend_v    = pend_v;
    next_so        = so;
    next_soe       = soe;
    next_store_cnt = store_cnt;
    next_init      = 1'b0;
    next_rx_valid  = 1'b0;
    next_rx_data   = rx_data;
    next_dec_first = dec_first;
    if (init)
      next_wiper = stored;
    // Decoder side: the bus byte count runs ahead of the FIFO, so a flag of
    // its own marks the first byte after a start as the offset
    if (dec_if.valid)
    begin
      if (dec_first)
      begin
        next_offset    = dec_if.data;
        next_dec_first = 1'b0;
      end
      else if (offset == IWRA_OFS_ACCESS_SEL)
        next_sel_wiper = (dec_if.data == IWRA_SEL_WIPER);
      else if (offset == IWRA_OFS_POSITION)
      begin
        next_pend   = dec_if.data[6:0];
        next_pend_v = 1'b1;
      end
    end
    unique case (state)
      ST_WAIT:
      begin
        // Bus ignored and line released while the store runs
        next_soe = 1'b0;
        if (store_cnt == '0)
          next_state = ST_IDLE;
        else
          next_store_cnt = store_cnt - 1'b1;
      end
      default:
      begin
        if (start_c)
        begin
          next_state  = ST_ADDR;
          next_bitn   = '0;
          next_byten  = '0;
          next_soe    = 1'b0;
          next_pend_v = 1'b0;
          next_dec_first = 1'b1;
        end
        else if (stop_c)
        begin
          next_state = ST_IDLE;
          next_soe   = 1'b0;
          if (pend_v && !rw && !step_mode)
          begin
            next_pend_v = 1'b0;
            next_wiper  = pend;
            if (!sel_wiper)
            begin
              next_stored    = pend;
              next_store_cnt = ($clog2(STORE_CYCLES+1))'(STORE_CYCLES - 1);
              next_state     = ST_WAIT;
            end
          end
        end
        else
        begin
          unique case (state)
            ST_IDLE:
              next_soe = 1'b0;
            ST_ADDR, ST_RX:
              if (scl_rise)
              begin
                next_shift = {shift[6:0], sda};
                next_bitn  = bitn + 4'd1;
              end
              else if (scl_fall && bitn == 4'd8)
              begin
                next_bitn = '0;
                if (state == ST_ADDR && !addr_ok)
                  next_state = ST_IDLE;
                else
                begin
                  // Acknowledge each byte addressed to us
                  next_so    = 1'b0;
                  next_soe   = 1'b1;
                  next_state = ST_ACK;
                  if (state == ST_ADDR)
                  begin
                    next_rw        = shift[0];
                    next_step_mode = (shift[7:3] == IWRA_TYPE_STEP);
                  end
                  else
                  begin
                    next_rx_valid = 1'b1;
                    next_rx_data  = shift;
                  end
                  next_byten = (byten == 2'd3) ? byten : byten + 2'd1;
                end
              end
            ST_ACK:
              if (scl_fall)
              begin
                if (rw && byten == 2'd1)
                begin
                  // Selected register, MSB forced to zero
                  next_shift = {1'b0, sel_wiper ? wiper : stored};
                  next_so    = 1'b0;
                  next_soe   = 1'b1;
                  next_state = ST_TX;
                end
                else
                begin
                  next_soe   = 1'b0;
                  next_state = (step_mode && byten == 2'd2) ? ST_STEP : ST_RX;
                end
              end
            ST_TX:
              if (scl_fall)
              begin
                next_shift = {shift[6:0], 1'b0};
                next_bitn  = bitn + 4'd1;
                next_so    = shift[6];
                if (bitn == 4'd7)
                begin
                  next_soe   = 1'b0;
                  next_state = ST_TXACK;
                  next_bitn  = '0;
                end
              end
            ST_TXACK:
              if (scl_rise)
                next_state = sda ? ST_IDLE : ST_TXACK;
              else if (scl_fall)
              begin
                next_shift = {1'b0, sel_wiper ? wiper : stored};
                next_so    = 1'b0;
                next_soe   = 1'b1;
                next_state = ST_TX;
              end
            ST_STEP:
              if (scl_rise)
                next_wiper = step_pos(wiper, sda);
            default:
              next_state = ST_IDLE;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      state     <= ST_IDLE;
      shift     <= 8'h00;
      bitn      <= 4'h0;
      byten     <= 2'd0;
      rw        <= 1'b0;
      step_mode <= 1'b0;
      sel_wiper <= 1'b1;
      offset    <= 8'h00;
      wiper     <= IWRA_STORED_RESET;
      stored    <= IWRA_STORED_RESET;
      pend      <= 7'h00;
      pend_v    <= 1'b0;
      so        <= 1'b1;
      soe       <= 1'b0;
      store_cnt <= '0;
      init      <= 1'b1;
      rx_valid  <= 1'b0;
      rx_data   <= 8'h00;
      dec_first <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      shift     <= next_shift;
      bitn      <= next_bitn;
      byten     <= next_byten;
      rw        <= next_rw;
      step_mode <= next_step_mode;
      sel_wiper <= next_sel_wiper;
      offset    <= next_offset;
      wiper     <= next_wiper;
      stored    <= next_stored;
      pend      <= next_pend;
      pend_v    <= next_pend_v;
      so        <= next_so;
      soe       <= next_soe;
      store_cnt <= next_store_cnt;
      init      <= next_init;
      rx_valid  <= next_rx_valid;
      rx_data   <= next_rx_data;
      dec_first <= next_dec_first;
    end
  end

  // Outputs straight from flops; open drain drives low only
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      sda_o             <= 1'b0;
      sda_oe_o          <= 1'b0;
      wiper_position_o  <= IWRA_STORED_RESET;
      stored_position_o <= IWRA_STORED_RESET;
      store_busy_o      <= 1'b0;
    end
    else
    begin
      sda_o             <= 1'b0;
      sda_oe_o          <= next_soe && !next_so;
      wiper_position_o  <= next_wiper;
      stored_position_o <= next_stored;
      store_busy_o      <= (next_state == ST_WAIT);
    end
  end
endmodule : iwra_target
`default_nettype wire

//--- test/iwra_master.sv
// Partner: I2C bus master model, SCL period of eight system clocks
`timescale 1ns/100ps
`default_nettype none
module iwra_master (
  // Clock
  input  wire logic mclk_i,
  // Bus lines
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Bus idles released, pull-up level
  initial scl_o = 1'b1;
  initial sda_o = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Data moves mid-low; sampled late in high so a slow ack still lands
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    sda_o <= b;
    tick(2);
    scl_o <= 1'b1;
    tick(3);
    r = sda_i;
    tick(1);
    scl_o <= 1'b0;
  endtask
  // Start or repeated start; SCL rises only after a held ack is released,
  // otherwise the release would look like a stop
  task automatic start_c;
    tick(2);
    sda_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
  endtask
  task automatic stop_c;
    tick(2);
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b1;
    tick(4);
  endtask
  // MSB first, ninth bit released; nack is the level seen there
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nack);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(1'b1, nack);
  endtask
endmodule // iwra_master
`default_nettype wire

//--- test/iwra_target_asserts.sv
// Checker: port-level properties of the wiper register I2C target
`timescale 1ns/100ps
`default_nettype none
module iwra_target_asserts #(
  parameter int STORE_CYCLES = 50
) (
  // Clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  // I2C pins
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  // Address straps
  input wire logic       addr_select_hi_i,
  input wire logic       addr_select_lo_i,
  // Register state
  input wire logic [6:0] wiper_position_o,
  input wire logic [6:0] stored_position_o,
  input wire logic       store_busy_o
);
  int busy_cnt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Length of the running store wait; slack of two covers the stop detect latency
  always_ff @(posedge mclk_i)
    if (!rst_b_i || !store_busy_o)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  // Store wait ends with both positions equal
  sequence s_store_end; store_busy_o ##1 !store_busy_o; endsequence
  property p_open_drain; sda_o == 1'b0; endproperty
  property p_busy_quiet; store_busy_o |-> !sda_oe_o; endproperty
  property p_busy_frozen; store_busy_o && $past(store_busy_o) |-> $stable(wiper_position_o); endproperty
  property p_busy_bound; store_busy_o |-> busy_cnt <= STORE_CYCLES + 2; endproperty
  property p_store_match; s_store_end |-> wiper_position_o == stored_position_o; endproperty
  property p_stored_cause; !$stable(stored_position_o) |-> ##[0:2] store_busy_o; endproperty
  property p_recall; $rose(rst_b_i) |-> ##[0:2] wiper_position_o == stored_position_o; endproperty
  property p_no_wrap_hi; $past(wiper_position_o) == 7'h7F |-> wiper_position_o != 7'h00; endproperty
  property p_no_wrap_lo; $past(wiper_position_o) == 7'h00 |-> wiper_position_o != 7'h7F; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  a_busy_quiet: assert property (p_busy_quiet) else $error("data pulled during store");
  a_busy_frozen: assert property (p_busy_frozen) else $error("wiper moved during store");
  a_busy_bound: assert property (p_busy_bound) else $error("store wait too long");
  a_store_match: assert property (p_store_match) else $error("positions differ after store");
  a_stored_cause: assert property (p_stored_cause) else $error("stored changed without store");
  a_recall: assert property (p_recall) else $error("wiper not recalled");
  a_no_wrap_hi: assert property (p_no_wrap_hi) else $error("wiper wrapped at top");
  a_no_wrap_lo: assert property (p_no_wrap_lo) else $error("wiper wrapped at bottom");
endmodule // iwra_target_asserts
bind iwra_target iwra_target_asserts #(.STORE_CYCLES(STORE_CYCLES)) iwra_target_asserts_i (.mclk_i, .rst_b_i,
  .scl_i, .sda_i, .sda_o, .sda_oe_o, .addr_select_hi_i, .addr_select_lo_i, .wiper_position_o,
  .stored_position_o, .store_busy_o);
`default_nettype wire

//--- test/tb.sv
// Testbench: I2C master scenarios against the wiper register target
`timescale 1ns/100ps
`default_nettype none
module tb;
  import iwra_pkg::*;
  localparam int STORE = 200;
  localparam logic [7:0] AW = {IWRA_TYPE_ACCESS, 2'b10, 1'b0};
  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic       scl;
  logic       m_sda;
  logic       sda_o;
  logic       sda_oe;
  logic [6:0] wiper;
  logic [6:0] stored;
  logic       busy;
  logic       a_hi = 1'b1;
  logic       a_lo = 1'b0;
  logic [7:0] d;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  // Open-drain line with pull-up
  wire logic  sda_line = m_sda & ~sda_oe;
  always #4 mclk = ~mclk;
  iwra_target #(.STORE_CYCLES(STORE)) iwra_target_i (.mclk_i(mclk), .rst_b_i(rst_b), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_hi_i(a_hi), .addr_select_lo_i(a_lo),
    .wiper_position_o(wiper), .stored_position_o(stored), .store_busy_o(busy));
  iwra_master iwra_master_i (.mclk_i(mclk), .sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Byte the target must acknowledge
  task automatic tx(input logic [7:0] b);
    logic [7:0] q;
    logic       n;
    iwra_master_i.xfer(b, q, n);
    check({7'h00, n}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    iwra_master_i.start_c();
    tx(AW);
    tx(a);
    tx(v);
    iwra_master_i.stop_c();
  endtask
  task automatic rd(output logic [7:0] v);
    logic n;
    iwra_master_i.start_c();
    tx(AW);
    tx(IWRA_OFS_POSITION);
    iwra_master_i.start_c();
    tx(AW | 8'h01);
    iwra_master_i.xfer(8'hFF, v, n);
    iwra_master_i.stop_c();
  endtask
  // Byte the target must refuse
  task automatic nk(input logic [7:0] b);
    logic [7:0] q;
    logic       n;
    iwra_master_i.start_c();
    iwra_master_i.xfer(b, q, n);
    iwra_master_i.stop_c();
    check({7'h00, n}, 8'h01);
  endtask
  task automatic t_recall;
    check({1'b0, wiper}, {1'b0, IWRA_STORED_RESET});
    check({1'b0, stored}, {1'b0, IWRA_STORED_RESET});
    $display("test recall done");
  endtask
  task automatic t_wiper;
    wr(IWRA_OFS_ACCESS_SEL, IWRA_SEL_WIPER);
    wr(IWRA_OFS_POSITION, 8'hD5);
    check({1'b0, wiper}, 8'h55);
    check({1'b0, stored}, 8'h40);
    rd(d);
    check(d, 8'h55);
    $display("test wiper done");
  endtask
  task automatic t_step;
    logic r;
    wr(IWRA_OFS_POSITION, 8'h7C);
    iwra_master_i.start_c();
    tx({IWRA_TYPE_STEP, 2'b10, 1'b0});
    tx(IWRA_OFS_POSITION);
    repeat (8) iwra_master_i.bit_x(1'b1, r);
    check({1'b0, wiper}, 8'h7F);
    repeat (2) iwra_master_i.bit_x(1'b0, r);
    check({1'b0, wiper}, 8'h7D);
    // The stop's own clock rise, taken with data low, is the third down step
    iwra_master_i.stop_c();
    check({1'b0, wiper}, 8'h7C);
    $display("test step done");
  endtask
  task automatic t_stored;
    logic [7:0] q;
    logic       n;
    int         tries;
    wr(IWRA_OFS_ACCESS_SEL, IWRA_SEL_STORED);
    wr(IWRA_OFS_POSITION, 8'h9A);
    check({7'h00, busy}, 8'h01);
    check({1'b0, stored}, 8'h1A);
    check({1'b0, wiper}, 8'h1A);
    tries = 0;
    n = 1'b1;
    // Ack polling, bounded
    while (n && tries < 10)
    begin
      iwra_master_i.start_c();
      iwra_master_i.xfer(AW, q, n);
      iwra_master_i.stop_c();
      tries++;
    end
    check({7'h00, tries > 1}, 8'h01);
    check({7'h00, n}, 8'h00);
    rd(d);
    check(d, 8'h1A);
    check({1'b0, wiper}, 8'h1A);
    $display("test stored done");
  endtask
  task automatic t_refuse;
    nk({IWRA_TYPE_ACCESS, 2'b01, 1'b0});
    nk({5'h1C, 2'b10, 1'b0});
    // Move the straps: the old address is now refused, the new one taken
    a_hi <= 1'b0;
    a_lo <= 1'b1;
    repeat (4) @(posedge mclk);
    nk(AW);
    iwra_master_i.start_c();
    tx({IWRA_TYPE_ACCESS, 2'b01, 1'b0});
    iwra_master_i.stop_c();
    a_hi <= 1'b1;
    a_lo <= 1'b0;
    $display("test refuse done");
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
    t_recall();
    t_wiper();
    t_step();
    t_stored();
    t_refuse();
    stop_test();
  end
endmodule // tb
`default_nettype wire
